// file: design/crc_gen_regs.svh
// Register offsets, field positions, reset values and counts of the CRC generator.
// Assumes inclusion by the package, the CRC top module, the checker and the testbench.
`ifndef CRC_GEN_REGS_SVH
`define CRC_GEN_REGS_SVH

`define CRC_ADDR_W 6
`define CRC_OFS_CTRL1 6'h00
`define CRC_OFS_CTRL2 6'h04
`define CRC_OFS_POLY_LO 6'h08
`define CRC_OFS_POLY_HI 6'h0c
`define CRC_OFS_DATA_LO 6'h10
`define CRC_OFS_DATA_HI 6'h14
`define CRC_OFS_RES_LO 6'h18
`define CRC_OFS_RES_HI 6'h1c
`define CRC_OFS_IRQ_STAT 6'h20
`define CRC_OFS_IRQ_MASK 6'h24

`define CRC_C1_EN 15
`define CRC_C1_VALID_WORD_COUNT_HI 12
`define CRC_C1_VALID_WORD_COUNT_LO 8
`define CRC_C1_FULL 7
`define CRC_C1_EMPTY 6
`define CRC_C1_ISEL 5
`define CRC_C1_GO 4
`define CRC_C1_LSB 3
`define CRC_C2_DW_HI 12
`define CRC_C2_DW_LO 8
`define CRC_C2_PL_HI 4
`define CRC_C2_PL_LO 0

`define CRC_RST_CTRL 4'h0
`define CRC_RST_DW 5'h00
`define CRC_RST_PL 5'h00
`define CRC_RST_POLY 32'h0000_0000
`define CRC_RST_RES 32'h0000_0000

`define CRC_DEPTH_WIDE 5'h04
`define CRC_DEPTH_MID 5'h08
`define CRC_DEPTH_NARROW 5'h10
`define CRC_DW_MID_MIN 5'h08
`define CRC_DW_WIDE_MIN 5'h10
`define CRC_BITS_PER_CYCLE 2

`define CRC_RESP_OKAY 2'h0
`define CRC_RESP_SLVERR 2'h2

`endif

// file: design/crc_gen_pkg.sv
// Types used by the CRC generator; its bench does not import them.
// Assumes the register header sits beside this file.
`include "crc_gen_regs.svh"

package crc_gen_pkg;

  typedef struct packed {
    logic en;
    logic isel;
    logic go;
    logic lsb_first;
  } crc_ctrl_t;

  typedef struct packed {
    logic [4:0] data_width_field;
    logic [4:0] poly_length_field;
  } crc_cfg_t;

  typedef enum logic {
    ENG_IDLE,
    ENG_SHIFT
  } eng_state_t;

endpackage

// file: design/crc_gen.sv
// Programmable CRC generator with data FIFO, AXI4-Lite register slave and interrupt.
// Assumes one clock, a synchronous active-high reset and a single AXI4-Lite master.
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "crc_gen_regs.svh"

// Contract
// - Polynomial order up to 32, five-bit length
// - Set term bit enables XOR at position
// - Constant term always XORed; top term implied
// - Data width is width field plus one
// - FIFO depth 4, 8 or 16 by width
// - Byte writes; bits above width ignored
// - Count increments on MSb byte write
// - Shifting starts on go with count nonzero
// - Word moves to buffer, count decrements
// - Two bits per cycle until count zero
// - Full flag at depth maximum
// - Empty flag when count is zero
// - Disabled module flushes FIFO, count zero
// - Selectable LSb-first or MSb-first shifting
module crc_gen
  import crc_gen_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int FIFO_SLOTS = 16
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [`CRC_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [`CRC_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic irq_o
);

  function automatic logic [4:0] depth_of(input logic [4:0] dw);
    depth_of = (dw >= `CRC_DW_WIDE_MIN) ? `CRC_DEPTH_WIDE :
               (dw >= `CRC_DW_MID_MIN) ? `CRC_DEPTH_MID : `CRC_DEPTH_NARROW;
  endfunction

  // One CRC step; feedback taken from bit (order-1).
  function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic din,
                                           input logic [31:0] terms, input logic [4:0] pl);
    logic [31:0] mask;
    logic fb;
    mask = 32'hffff_ffff >> (5'h1f - pl);
    fb = crc[pl] ^ din;
    crc_step = (crc << 1) & mask;
    if (fb) begin
      crc_step = crc_step ^ ((terms | 32'h0000_0001) & mask);
    end
  endfunction

  function automatic logic [31:0] width_mask(input logic [4:0] dw);
    width_mask = 32'hffff_ffff >> (5'h1f - dw);
  endfunction

  crc_ctrl_t ctrl_q;
  crc_cfg_t cfg_q;
  logic [31:0] poly_q, result_q, stage_q;
  logic [DATA_W-1:0] fifo_mem_q [FIFO_SLOTS];
  logic [3:0] wr_ptr_q, rd_ptr_q;
  logic [4:0] count_q;
  logic [DATA_W-1:0] buf_q;
  logic [5:0] bit_idx_q;
  eng_state_t state_q;
  logic stat_q, mask_q;
  logic aw_full_q, w_full_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q, irq_q;
  logic [`CRC_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;

  logic wr_fire, full, msb_lane_hit, push, pop, empty_event, done_event, last_bits;
  logic [4:0] depth;
  logic [5:0] width;
  logic [31:0] push_word, merged, step_one, step_two;

  assign wr_fire = aw_full_q & w_full_q & ~bvalid_q;
  assign depth = depth_of(cfg_q.data_width_field);
  assign full = (count_q >= depth);
  assign width = {1'b0, cfg_q.data_width_field} + 6'h01;

  // Byte lanes of the data pair map onto bytes 0..3 of the word
  always_comb begin
    merged = stage_q;
    for (int i = 0; i < 2; i++) begin
      if (wstrb_q[i] && awaddr_q == `CRC_OFS_DATA_LO) begin
        merged[8*i +: 8] = wdata_q[8*i +: 8];
      end
      if (wstrb_q[i] && awaddr_q == `CRC_OFS_DATA_HI) begin
        merged[16 + 8*i +: 8] = wdata_q[8*i +: 8];
      end
    end
  end

  always_comb begin
    msb_lane_hit = 1'b0;
    unique case (cfg_q.data_width_field[4:3])
      2'd0: msb_lane_hit = awaddr_q == `CRC_OFS_DATA_LO && wstrb_q[0];
      2'd1: msb_lane_hit = awaddr_q == `CRC_OFS_DATA_LO && wstrb_q[1];
      2'd2: msb_lane_hit = awaddr_q == `CRC_OFS_DATA_HI && wstrb_q[0];
      2'd3: msb_lane_hit = awaddr_q == `CRC_OFS_DATA_HI && wstrb_q[1];
    endcase
  end

  // A word arriving into a full FIFO is dropped
  assign push = wr_fire & msb_lane_hit & ctrl_q.en & ~full;
  assign push_word = merged & width_mask(cfg_q.data_width_field);
  assign pop = ctrl_q.en & ctrl_q.go & (count_q != 5'h00) & (state_q == ENG_IDLE);
  assign last_bits = ({1'b0, bit_idx_q} + 7'd`CRC_BITS_PER_CYCLE) >= {1'b0, width};
  assign done_event = (state_q == ENG_SHIFT) & last_bits & (count_q == 5'h00);
  assign empty_event = pop & ~push & (count_q == 5'h01);

  // AXI4-Lite write channels; address and data taken in either order
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `CRC_RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (s_axi_awvalid_i && awready_q) begin
        aw_full_q <= 1'b1;
        awready_q <= 1'b0;
        awaddr_q <= {s_axi_awaddr_i[`CRC_ADDR_W-1:2], 2'b00};
      end
      if (s_axi_wvalid_i && wready_q) begin
        w_full_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= (awaddr_q > `CRC_OFS_IRQ_MASK) ? `CRC_RESP_SLVERR : `CRC_RESP_OKAY;
      end
      if (bvalid_q && s_axi_bready_i) begin
        bvalid_q <= 1'b0;
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= `CRC_RESP_OKAY;
    end else if (s_axi_arvalid_i && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= `CRC_RESP_OKAY;
      rdata_q <= '0;
      unique case ({s_axi_araddr_i[`CRC_ADDR_W-1:2], 2'b00})
        `CRC_OFS_CTRL1: begin
          rdata_q[`CRC_C1_EN] <= ctrl_q.en;
          rdata_q[`CRC_C1_VALID_WORD_COUNT_HI:`CRC_C1_VALID_WORD_COUNT_LO] <= count_q;
          rdata_q[`CRC_C1_FULL] <= full;
          rdata_q[`CRC_C1_EMPTY] <= (count_q == 5'h00);
          rdata_q[`CRC_C1_ISEL] <= ctrl_q.isel;
          rdata_q[`CRC_C1_GO] <= ctrl_q.go;
          rdata_q[`CRC_C1_LSB] <= ctrl_q.lsb_first;
        end
        `CRC_OFS_CTRL2: begin
          rdata_q[`CRC_C2_DW_HI:`CRC_C2_DW_LO] <= cfg_q.data_width_field;
          rdata_q[`CRC_C2_PL_HI:`CRC_C2_PL_LO] <= cfg_q.poly_length_field;
        end
        `CRC_OFS_POLY_LO: rdata_q[15:0] <= poly_q[15:0];
        `CRC_OFS_POLY_HI: rdata_q[15:0] <= poly_q[31:16];
        `CRC_OFS_DATA_LO: rdata_q[15:0] <= stage_q[15:0];
        `CRC_OFS_DATA_HI: rdata_q[15:0] <= stage_q[31:16];
        `CRC_OFS_RES_LO: rdata_q[15:0] <= result_q[15:0];
        `CRC_OFS_RES_HI: rdata_q[15:0] <= result_q[31:16];
        `CRC_OFS_IRQ_STAT: rdata_q[0] <= stat_q;
        `CRC_OFS_IRQ_MASK: rdata_q[0] <= mask_q;
        default: rresp_q <= `CRC_RESP_SLVERR;
      endcase
    end else if (rvalid_q && s_axi_rready_i) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // Control and configuration registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_q <= `CRC_RST_CTRL;
      cfg_q <= {`CRC_RST_DW, `CRC_RST_PL};
      poly_q <= `CRC_RST_POLY;
      stage_q <= '0;
      mask_q <= 1'b0;
    end else if (wr_fire) begin
      stage_q <= merged;
      unique case (awaddr_q)
        `CRC_OFS_CTRL1: begin
          if (wstrb_q[1]) begin
            ctrl_q.en <= wdata_q[`CRC_C1_EN];
          end
          if (wstrb_q[0]) begin
            ctrl_q.isel <= wdata_q[`CRC_C1_ISEL];
            ctrl_q.go <= wdata_q[`CRC_C1_GO];
            ctrl_q.lsb_first <= wdata_q[`CRC_C1_LSB];
          end
        end
        `CRC_OFS_CTRL2: begin
          if (wstrb_q[1]) begin
            cfg_q.data_width_field <= wdata_q[`CRC_C2_DW_HI:`CRC_C2_DW_LO];
          end
          if (wstrb_q[0]) begin
            cfg_q.poly_length_field <= wdata_q[`CRC_C2_PL_HI:`CRC_C2_PL_LO];
          end
        end
        `CRC_OFS_POLY_LO: poly_q[15:0] <= wdata_q[15:0];
        `CRC_OFS_POLY_HI: poly_q[31:16] <= wdata_q[15:0];
        `CRC_OFS_IRQ_MASK: mask_q <= wdata_q[0];
        default: ;
      endcase
    end
  end

  // Data FIFO; depth limited by the count, pointers wrap at the slot count
  always_ff @(posedge clk_i) begin
    if (srst_i || !ctrl_q.en) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        fifo_mem_q[wr_ptr_q] <= push_word[DATA_W-1:0];
        wr_ptr_q <= wr_ptr_q + 4'h1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 4'h1;
      end
      count_q <= count_q + {4'h0, push} - {4'h0, pop};
    end
  end

  // Shift engine: buffer load, then two bits a cycle
  always_ff @(posedge clk_i) begin
    if (srst_i || !ctrl_q.en) begin
      state_q <= ENG_IDLE;
      buf_q <= '0;
      bit_idx_q <= '0;
    end else begin
      unique case (state_q)
        ENG_IDLE: begin
          if (pop) begin
            buf_q <= fifo_mem_q[rd_ptr_q];
            bit_idx_q <= '0;
            state_q <= ENG_SHIFT;
          end
        end
        ENG_SHIFT: begin
          bit_idx_q <= bit_idx_q + 6'd`CRC_BITS_PER_CYCLE;
          if (last_bits) begin
            state_q <= ENG_IDLE;
          end
        end
      endcase
    end
  end

  function automatic logic pick_bit(input logic [DATA_W-1:0] b, input logic [5:0] idx,
                                    input logic [5:0] w, input logic lsb);
    pick_bit = lsb ? b[idx[4:0]] : b[5'(w - 6'h01 - idx)];
  endfunction

  // Two steps a cycle; an odd width takes only the first in its final cycle
  assign step_one = crc_step(result_q, pick_bit(buf_q, bit_idx_q, width, ctrl_q.lsb_first),
                             poly_q, cfg_q.poly_length_field);
  assign step_two = crc_step(step_one,
                             pick_bit(buf_q, bit_idx_q + 6'h01, width, ctrl_q.lsb_first),
                             poly_q, cfg_q.poly_length_field);

  // Result register; a software write seeds it and wins over the engine
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      result_q <= `CRC_RST_RES;
    end else if (wr_fire && awaddr_q == `CRC_OFS_RES_LO) begin
      result_q[15:0] <= wdata_q[15:0];
    end else if (wr_fire && awaddr_q == `CRC_OFS_RES_HI) begin
      result_q[31:16] <= wdata_q[15:0];
    end else if (state_q == ENG_SHIFT) begin
      result_q <= (bit_idx_q + 6'h01 < width) ? step_two : step_one;
    end
  end

  // Sticky status; a new event wins over a same-cycle clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      stat_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      if (ctrl_q.isel ? empty_event : done_event) begin
        stat_q <= 1'b1;
      end else if (wr_fire && awaddr_q == `CRC_OFS_IRQ_STAT && wstrb_q[0] && wdata_q[0]) begin
        stat_q <= 1'b0;
      end
      irq_q <= stat_q & mask_q;
    end
  end

  assign {s_axi_awready_o, s_axi_wready_o, s_axi_arready_o} = {awready_q, wready_q, arready_q};
  assign {s_axi_bvalid_o, s_axi_rvalid_o, irq_o} = {bvalid_q, rvalid_q, irq_q};
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;

endmodule

// file: bench/crc_gen_asserts.sv
// Port-level checker for the CRC generator's register slave and interrupt.
// Assumes it is bound into crc_gen and sees only that module's ports.
`timescale 1ns/1ps
`include "crc_gen_regs.svh"
module crc_gen_asserts #(
  parameter int DATA_W = 32,
  parameter int FIFO_SLOTS = 16
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [`CRC_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [`CRC_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  logic wtake;
  logic rtake;
  assign wtake = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  assign rtake = s_axi_arvalid_i && s_axi_arready_o;

  reset_idle_a: assert property (disable iff (1'b0) srst_i |=> s_axi_awready_o &&
    s_axi_arready_o && !s_axi_bvalid_o && !s_axi_rvalid_o && !irq_o)
    else $error("outputs not idle after reset");
  write_answer_a: assert property (wtake |=> !s_axi_awready_o ##1 s_axi_bvalid_o)
    else $error("write response late or slave still ready");
  write_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped before taken");
  read_answer_a: assert property (rtake |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read data late or slave still ready");
  read_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data changed before taken");
  read_unmapped_a: assert property (rtake && s_axi_araddr_i[5:2] > 4'h9 |=>
    s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 32'h0)
    else $error("unmapped read not refused");
  read_mapped_a: assert property (rtake && s_axi_araddr_i[5:2] <= 4'h9 |=>
    s_axi_rresp_o == 2'h0)
    else $error("mapped read refused");
  write_unmapped_a: assert property (wtake && s_axi_awaddr_i[5:2] > 4'h9 |->
    ##2 s_axi_bresp_o == 2'h2)
    else $error("unmapped write not refused");
  irq_masked_a: assert property (
    wtake && s_axi_awaddr_i == `CRC_OFS_IRQ_MASK && !s_axi_wdata_i[0] |-> ##3 !irq_o)
    else $error("interrupt high while masked");
endmodule

bind crc_gen crc_gen_asserts #(.DATA_W(DATA_W), .FIFO_SLOTS(FIFO_SLOTS)) u_chk (.*);

// file: bench/crc_gen_tb_top.sv
// Register-level testbench of the CRC generator over AXI4-Lite.
// Assumes the design and its register header are compiled alongside.
`timescale 1ns/1ps
`include "crc_gen_regs.svh"
module crc_gen_tb_top;
  logic clk_i = 0;
  logic srst_i = 1;
  logic [`CRC_ADDR_W-1:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0;
  logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
  logic s_axi_arvalid_i = 0, s_axi_rready_i = 0;
  logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i = 0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic s_axi_arready_o, s_axi_rvalid_o, irq_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  int miscompares = 0;
  int checked = 0;
  int wl[5] = '{7, 8, 15, 16, 31};

  crc_gen uut (.*);

  always #2 clk_i = ~clk_i;

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask

  // Ready is sampled at the falling edge, where it is settled for the next take
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    logic da, dw, ta, tw;
    da = 0;
    dw = 0;
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wdata_i <= d;
    s_axi_wstrb_i <= s;
    s_axi_wvalid_i <= 1'b1;
    while (!(da && dw)) begin
      @(negedge clk_i);
      ta = s_axi_awready_o && !da;
      tw = s_axi_wready_o && !dw;
      @(posedge clk_i);
      if (ta) begin
        s_axi_awvalid_i <= 1'b0;
        da = 1;
      end
      if (tw) begin
        s_axi_wvalid_i <= 1'b0;
        dw = 1;
      end
    end
    do @(negedge clk_i); while (!s_axi_bvalid_o);
    // Ready raised late on purpose so the response must stand a cycle
    @(posedge clk_i);
    s_axi_bready_i <= 1'b1;
    @(negedge clk_i);
    r = s_axi_bresp_o;
    @(posedge clk_i);
    s_axi_bready_i <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    do @(negedge clk_i); while (!s_axi_arready_o);
    @(posedge clk_i);
    s_axi_arvalid_i <= 1'b0;
    do @(negedge clk_i); while (!s_axi_rvalid_o);
    @(posedge clk_i);
    s_axi_rready_i <= 1'b1;
    @(negedge clk_i);
    d = s_axi_rdata_o;
    r = s_axi_rresp_o;
    @(posedge clk_i);
    s_axi_rready_i <= 1'b0;
  endtask

  task automatic rdc(input logic [5:0] a, input logic [31:0] e, input string n);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(n, e, d);
  endtask

  task automatic wrq(input logic [5:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, 4'hf, r);
  endtask

  // Lower bytes first; the write holding the top bit completes the word
  task automatic push(input logic [4:0] f, input logic [31:0] v);
    logic [1:0] r;
    if (f < 5'd8)
      wr(`CRC_OFS_DATA_LO, v, 4'h1, r);
    else begin
      wr(`CRC_OFS_DATA_LO, v & 32'hffff, 4'h3, r);
      if (f >= 5'd16)
        wr(`CRC_OFS_DATA_HI, v >> 16, (f < 5'd24) ? 4'h1 : 4'h3, r);
    end
  endtask

  function automatic logic [31:0] crc_ref(input logic [31:0] sd, input logic [31:0] tm,
      input logic [31:0] dt, input logic [4:0] pl, input logic [4:0] dwf, input logic lsb);
    logic [31:0] c, m;
    logic fb;
    m = (pl == 5'h1f) ? 32'hffff_ffff : ((32'h1 << (pl + 1)) - 32'h1);
    c = sd & m;
    for (int i = 0; i <= dwf; i++) begin
      fb = c[pl] ^ (lsb ? dt[i] : dt[dwf - i]);
      c = (c << 1) & m;
      if (fb)
        c = c ^ ((tm | 32'h1) & m);
    end
    return c;
  endfunction

  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    summarize();
  end

  initial begin
    logic [31:0] d, e, tm, sd, dt;
    logic [1:0] r;
    logic [4:0] pl, f;
    logic lsb;
    int dep;
    repeat (4) @(posedge clk_i);
    srst_i <= 1'b0;
    for (int a = 0; a < 10; a++)
      rdc(6'(a * 4), (a == 0) ? 32'h40 : 32'h0, "reset value");
    rd(6'h28, d, r);
    chk("unmapped read resp", 32'h2, {30'h0, r});
    wr(6'h2c, 32'h1, 4'hf, r);
    chk("unmapped write resp", 32'h2, {30'h0, r});
    wrq(`CRC_OFS_CTRL2, 32'h1f1f);
    rdc(`CRC_OFS_CTRL2, 32'h1f1f, "ctrl2 readback");
    push(5'h1f, 32'h1234_5678);
    rdc(`CRC_OFS_CTRL1, 32'h40, "count while disabled");
    wrq(`CRC_OFS_CTRL1, 32'h8000);
    wr(`CRC_OFS_DATA_LO, 32'h5678, 4'h3, r);
    rdc(`CRC_OFS_CTRL1, 32'h8040, "count after low half");
    wr(`CRC_OFS_DATA_HI, 32'h1234, 4'h3, r);
    rdc(`CRC_OFS_CTRL1, 32'h8100, "count after high half");
    wrq(`CRC_OFS_CTRL1, 32'h0);
    $display("test reset and map done");
    foreach (wl[k]) begin
      f = 5'(wl[k]);
      dep = (f > 15) ? 4 : (f > 7) ? 8 : 16;
      wrq(`CRC_OFS_CTRL1, 32'h8000);
      wrq(`CRC_OFS_CTRL2, {19'h0, f, 8'h0});
      for (int j = 0; j <= dep; j++)
        push(f, 32'hffff_ffff);
      rdc(`CRC_OFS_CTRL1, 32'h8080 | (dep << 8), "full count");
      wrq(`CRC_OFS_CTRL1, 32'h0);
      rdc(`CRC_OFS_CTRL1, 32'h40, "flushed count");
    end
    $display("test fifo depth done");
    for (int k = 0; k < 2; k++) begin
      pl = k ? 5'h1f : 5'h0f;
      tm = k ? 32'h04c1_1db7 : 32'h1021;
      sd = k ? 32'hffff_ffff : 32'hffff;
      dt = k ? 32'h89ab_cdef : 32'h3132;
      lsb = k[0];
      e = crc_ref(sd, tm, dt, pl, pl, lsb);
      wrq(`CRC_OFS_CTRL1, 32'h8000 | (lsb << 3));
      wrq(`CRC_OFS_CTRL2, {19'h0, pl, 3'h0, pl});
      wrq(`CRC_OFS_POLY_LO, tm & 32'hffff);
      wrq(`CRC_OFS_POLY_HI, tm >> 16);
      wrq(`CRC_OFS_RES_LO, sd & 32'hffff);
      wrq(`CRC_OFS_RES_HI, sd >> 16);
      wrq(`CRC_OFS_IRQ_MASK, {31'h0, !k[0]});
      push(pl, dt);
      repeat (20) @(posedge clk_i);
      rdc(`CRC_OFS_CTRL1, 32'h8100 | (lsb << 3), "count before go");
      wrq(`CRC_OFS_CTRL1, 32'h8010 | (k << 5) | (lsb << 3));
      d = 0;
      for (int i = 0; i < 50 && !d[0]; i++)
        rd(`CRC_OFS_IRQ_STAT, d, r);
      chk("status event", 32'h1, d);
      repeat (40) @(posedge clk_i);
      @(negedge clk_i);
      chk("irq level", {31'h0, !k[0]}, {31'h0, irq_o});
      rdc(`CRC_OFS_CTRL1, 32'h8050 | (k << 5) | (lsb << 3), "count after run");
      rdc(`CRC_OFS_RES_LO, e & 32'hffff, "crc low");
      rdc(`CRC_OFS_RES_HI, e >> 16, "crc high");
      wrq(`CRC_OFS_IRQ_STAT, 32'h1);
      rdc(`CRC_OFS_IRQ_STAT, 32'h0, "status cleared");
      @(negedge clk_i);
      chk("irq cleared", 32'h0, {31'h0, irq_o});
      wrq(`CRC_OFS_CTRL1, 32'h0);
    end
    $display("test crc runs done");
    summarize();
  end
endmodule
